// File: hw/dio_pkg.sv
// Purpose: shared constants and types for the dual 8-bit i/o port block
// Assumes: apb slave with 32-bit data, one register per aligned word
// Notes: printed offsets are not multiples of four, so they are indices
package dio_pkg;
   localparam int unsigned DIO_W = 8;
   // register indices as printed; byte address is four times the index
   localparam logic [15:0] DIO_IDX_P7_DATA = 16'hffda;
   localparam logic [15:0] DIO_IDX_P8_DATA = 16'hffdb;
   localparam logic [15:0] DIO_IDX_P7_DIR = 16'hffea;
   localparam logic [15:0] DIO_IDX_P8_DIR = 16'hffeb;
   // power mode control register of our own, index chosen freely
   localparam logic [15:0] DIO_IDX_MODE = 16'hfff0;
   localparam logic [7:0] DIO_DATA_RST = 8'h00;
   localparam logic [7:0] DIO_DIR_RST = 8'h00;
   localparam logic [7:0] DIO_WO_READ = 8'hff;
   localparam int unsigned DIO_SYNC_STAGES = 2;

   // power mode encoding held in the mode register
   typedef enum logic [2:0] {
      DIO_MODE_ACTIVE = 3'h0,
      DIO_MODE_SUBACTIVE = 3'h1,
      DIO_MODE_SLEEP = 3'h2,
      DIO_MODE_SUBSLEEP = 3'h3,
      DIO_MODE_WATCH = 3'h4,
      DIO_MODE_STANDBY = 3'h5
   } dio_mode_t;

   localparam dio_mode_t DIO_MODE_RST = DIO_MODE_ACTIVE;

   // pin bundle of one port
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe_n;
   } dio_pins_t;
endpackage : dio_pkg

// File: hw/dio_sync.sv
// Purpose: two-flop synchroniser for an 8-bit pin group
// Assumes: each bit is independent, no word coherence needed
// Notes: first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module dio_sync
   import dio_pkg::*;
#(
   parameter int unsigned W = DIO_W
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } dio_sync_st_t;

   dio_sync_st_t st_r;
   dio_sync_st_t st_nxt;

   always_comb begin
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.s2;
endmodule : dio_sync
`default_nettype wire

// File: hw/dio_ports.sv
// Purpose: two 8-bit general-purpose i/o ports behind an apb slave
// Assumes: power controller gives the operating mode through a register
// Notes: output enables are active low, high means the pin floats
// ======================================================================
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dio_ports
   import dio_pkg::*;
(
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // first port pins
   input wire logic [7:0] port_seven_pin_in,
   output logic [7:0] port_seven_pin_out,
   output logic [7:0] port_seven_pin_oe_n,
   // second port pins
   input wire logic [7:0] port_eight_pin_in,
   output logic [7:0] port_eight_pin_out,
   output logic [7:0] port_eight_pin_oe_n
);
   // ======================================================================
   // state
   typedef struct packed {
      logic [7:0] p7_data;
      logic [7:0] p7_dir;
      logic [7:0] p8_data;
      logic [7:0] p8_dir;
      dio_mode_t mode;
      dio_pins_t p7_pins;
      dio_pins_t p8_pins;
      logic [31:0] rdata;
      logic ready;
      logic err;
   } dio_st_t;

   dio_st_t st_r;
   dio_st_t st_nxt;
   logic [7:0] p7_sync;
   logic [7:0] p8_sync;

   // ======================================================================
   // pin synchronisers
   dio_sync #(.W(DIO_W)) u_sync7 (
      .pclk(pclk),
      .presetn(presetn),
      .d(port_seven_pin_in),
      .q(p7_sync)
   );

   dio_sync #(.W(DIO_W)) u_sync8 (
      .pclk(pclk),
      .presetn(presetn),
      .d(port_eight_pin_in),
      .q(p8_sync)
   );

   // ======================================================================
   // decode: word addresses, index is byte address over four
   logic [29:0] widx;
   logic sel_p7d;
   logic sel_p8d;
   logic sel_p7c;
   logic sel_p8c;
   logic sel_mode;
   logic setup;
   logic wr_ok;

   assign widx = paddr[31:2];
   assign sel_p7d = (widx == {14'h0000, DIO_IDX_P7_DATA});
   assign sel_p8d = (widx == {14'h0000, DIO_IDX_P8_DATA});
   assign sel_p7c = (widx == {14'h0000, DIO_IDX_P7_DIR});
   assign sel_p8c = (widx == {14'h0000, DIO_IDX_P8_DIR});
   assign sel_mode = (widx == {14'h0000, DIO_IDX_MODE});
   // answer is taken in the setup cycle so the access phase ends in one cycle
   assign setup = psel && !penable;
   // narrow data sits in byte lane 0, so only that strobe writes
   assign wr_ok = setup && pwrite && pstrb[0];

   // ======================================================================
   // pin drive for one port under the current mode
   function automatic dio_pins_t drive_pins(input dio_mode_t m, input logic [7:0] dat,
                                            input logic [7:0] dir, input dio_pins_t prev);
      dio_pins_t p;
      p = prev;
      case (m)
         DIO_MODE_ACTIVE, DIO_MODE_SUBACTIVE: begin
            p.out = dat;
            p.oe_n = ~dir;
         end
         DIO_MODE_STANDBY: begin
            p.out = 8'h00;
            p.oe_n = 8'hff;
         end
         // sleep, subsleep and watch keep the previous pin state
         default: p = prev;
      endcase
      return p;
   endfunction : drive_pins

   // ======================================================================
   // next state
   always_comb begin
      st_nxt = st_r;
      st_nxt.ready = 1'b0;
      st_nxt.err = 1'b0;
      if (setup) begin
         st_nxt.ready = 1'b1;
         st_nxt.rdata = 32'h0000_0000;
         st_nxt.err = !(sel_p7d || sel_p8d || sel_p7c || sel_p8c || sel_mode);
         if (!pwrite) begin
            if (sel_p7d) begin
               st_nxt.rdata[7:0] = (st_r.p7_data & st_r.p7_dir) | (p7_sync & ~st_r.p7_dir);
            end else if (sel_p8d) begin
               st_nxt.rdata[7:0] = (st_r.p8_data & st_r.p8_dir) | (p8_sync & ~st_r.p8_dir);
            end else if (sel_p7c || sel_p8c) begin
               st_nxt.rdata[7:0] = DIO_WO_READ;
            end else if (sel_mode) begin
               st_nxt.rdata[2:0] = st_r.mode;
            end
         end
      end
      if (wr_ok) begin
         if (sel_p7d) begin
            st_nxt.p7_data = pwdata[7:0];
         end
         if (sel_p8d) begin
            st_nxt.p8_data = pwdata[7:0];
         end
         if (sel_p7c) begin
            st_nxt.p7_dir = pwdata[7:0];
         end
         if (sel_p8c) begin
            st_nxt.p8_dir = pwdata[7:0];
         end
         if (sel_mode && pwdata[2:0] <= 3'h5) begin
            st_nxt.mode = dio_mode_t'(pwdata[2:0]);
         end
      end
      // pins follow the registered latch and direction one cycle later
      st_nxt.p7_pins = drive_pins(st_r.mode, st_r.p7_data, st_r.p7_dir, st_r.p7_pins);
      st_nxt.p8_pins = drive_pins(st_r.mode, st_r.p8_data, st_r.p8_dir, st_r.p8_pins);
   end

   // ======================================================================
   // registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
         st_r.p7_data <= DIO_DATA_RST;
         st_r.p7_dir <= DIO_DIR_RST;
         st_r.p8_data <= DIO_DATA_RST;
         st_r.p8_dir <= DIO_DIR_RST;
         st_r.mode <= DIO_MODE_RST;
         st_r.p7_pins.oe_n <= 8'hff;
         st_r.p8_pins.oe_n <= 8'hff;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata = st_r.rdata;
   assign pready = st_r.ready;
   assign pslverr = st_r.err;
   assign port_seven_pin_out = st_r.p7_pins.out;
   assign port_seven_pin_oe_n = st_r.p7_pins.oe_n;
   assign port_eight_pin_out = st_r.p8_pins.out;
   assign port_eight_pin_oe_n = st_r.p8_pins.oe_n;

   // ======================================================================
   // assertions
   // pins follow the latch only in the two running modes
   logic mode_live;
   assign mode_live = (st_r.mode == DIO_MODE_ACTIVE) || (st_r.mode == DIO_MODE_SUBACTIVE);

   a_dir7_read_ones: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && sel_p7c) |=> (prdata[7:0] == 8'hff))
      else $error("first direction read not all ones");

   a_dir8_read_ones: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && sel_p8c) |=> (prdata == 32'h0000_00ff))
      else $error("second direction read not all ones");

   a_p7_read_mix: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && sel_p7d) |=>
         ((prdata[7:0] & $past(st_r.p7_dir)) == ($past(st_r.p7_data) & $past(st_r.p7_dir))))
      else $error("first port read lost latch bits");

   a_p7_read_pin: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && sel_p7d) |=>
         ((prdata[7:0] & ~$past(st_r.p7_dir)) == ($past(p7_sync) & ~$past(st_r.p7_dir))))
      else $error("first port read lost pin bits");

   a_p8_read_pin: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && sel_p8d) |=>
         ((prdata[7:0] & ~$past(st_r.p8_dir)) == ($past(p8_sync) & ~$past(st_r.p8_dir))))
      else $error("second port read lost pin bits");

   a_p7_write_latch: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_ok && sel_p7d) |=> (st_r.p7_data == $past(pwdata[7:0])))
      else $error("first port latch not written");

   a_p8_drive_out: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_live && $stable(st_r.mode)) |=>
         (port_eight_pin_oe_n == ~$past(st_r.p8_dir)) &&
         (port_eight_pin_out == $past(st_r.p8_data)))
      else $error("second port pins not driven from latch");

   a_p7_standby_float: assert property (@(posedge pclk) disable iff (!presetn)
      (st_r.mode == DIO_MODE_STANDBY) |=> (port_seven_pin_oe_n == 8'hff))
      else $error("first port not floating in standby");

   a_p8_sleep_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (st_r.mode == DIO_MODE_SLEEP) |=> $stable(port_eight_pin_oe_n) && $stable(port_eight_pin_out))
      else $error("second port pins changed in sleep");

   a_one_wait_ready: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready ##1 !pready)
      else $error("ready not a single pulse after setup");

   // ======================================================================
   // further bus checks
   a_bad_addr_err: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !(sel_p7d || sel_p8d || sel_p7c || sel_p8c || sel_mode)) |=>
         (pslverr && (prdata == 32'h0000_0000)))
      else $error("unmapped access not refused");

   a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready)
      else $error("error flag without ready");

   a_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
      pready |-> $past(psel && !penable))
      else $error("ready without a setup cycle before it");

   a_read_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite) |=> (prdata[31:8] == 24'h00_0000))
      else $error("read data upper bits not zero");

   // out of range codes are dropped so the pins never see an undefined mode
   a_mode_refused: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_ok && sel_mode && (pwdata[2:0] > 3'h5)) |=> $stable(st_r.mode))
      else $error("out of range mode accepted");

   // ======================================================================
   // further latch and direction checks
   a_p8_read_mix: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && sel_p8d) |=>
         ((prdata[7:0] & $past(st_r.p8_dir)) == ($past(st_r.p8_data) & $past(st_r.p8_dir))))
      else $error("second port read lost latch bits");

   a_p8_write_latch: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_ok && sel_p8d) |=> (st_r.p8_data == $past(pwdata[7:0])))
      else $error("second port latch not written");

   a_p7_dir_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_ok && sel_p7c) |=> (st_r.p7_dir == $past(pwdata[7:0])))
      else $error("first direction not written");

   a_p8_dir_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_ok && sel_p8c) |=> (st_r.p8_dir == $past(pwdata[7:0])))
      else $error("second direction not written");

   // a write without the lane 0 strobe is answered but must change nothing
   a_p7_strobe_off: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && pwrite && !pstrb[0] && sel_p7d) |=> $stable(st_r.p7_data))
      else $error("first port latch written without lane strobe");

   a_p7_reset_clear: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> (st_r.p7_data == DIO_DATA_RST) && (st_r.p7_dir == DIO_DIR_RST))
      else $error("first port not cleared by reset");

   a_p8_reset_clear: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(presetn) |->
         (st_r.p8_data == DIO_DATA_RST) && (st_r.p8_dir == DIO_DIR_RST))
      else $error("second port not cleared by reset");

   // ======================================================================
   // further pin checks
   a_reset_float: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> (port_seven_pin_oe_n == 8'hff) && (port_eight_pin_oe_n == 8'hff))
      else $error("pins not floating after reset");

   a_p7_drive_out: assert property (@(posedge pclk) disable iff (!presetn)
      mode_live |=>
         (port_seven_pin_oe_n == ~$past(st_r.p7_dir)) &&
         (port_seven_pin_out == $past(st_r.p7_data)))
      else $error("first port pins not driven from latch");

   a_p8_standby_float: assert property (@(posedge pclk) disable iff (!presetn)
      (st_r.mode == DIO_MODE_STANDBY) |=> (port_eight_pin_oe_n == 8'hff))
      else $error("second port not floating in standby");

   a_standby_low_out: assert property (@(posedge pclk) disable iff (!presetn)
      (st_r.mode == DIO_MODE_STANDBY) |=>
         (port_seven_pin_out == 8'h00) && (port_eight_pin_out == 8'h00))
      else $error("pins not parked low in standby");

   a_p7_hold_state: assert property (@(posedge pclk) disable iff (!presetn)
      (st_r.mode inside {DIO_MODE_SLEEP, DIO_MODE_SUBSLEEP, DIO_MODE_WATCH}) |=>
         $stable(port_seven_pin_oe_n) && $stable(port_seven_pin_out))
      else $error("first port pins changed while held");

   a_p8_hold_state: assert property (@(posedge pclk) disable iff (!presetn)
      (st_r.mode inside {DIO_MODE_SLEEP, DIO_MODE_SUBSLEEP, DIO_MODE_WATCH}) |=>
         $stable(port_eight_pin_oe_n) && $stable(port_eight_pin_out))
      else $error("second port pins changed while held");

   c_p7_read: cover property (@(posedge pclk) disable iff (!presetn)
      setup && !pwrite && sel_p7d ##1 pready);
   c_p8_write: cover property (@(posedge pclk) disable iff (!presetn)
      wr_ok && sel_p8d);
   c_standby: cover property (@(posedge pclk) disable iff (!presetn)
      st_r.mode == DIO_MODE_STANDBY);
   c_bad_addr: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
   c_hold_leave: cover property (@(posedge pclk) disable iff (!presetn)
      (st_r.mode == DIO_MODE_WATCH) ##1 mode_live);
endmodule : dio_ports
`default_nettype wire

// File: bench/dio_pin_model.sv
// Purpose: outside circuitry on the pins of one 8-bit port
// Assumes: a pin that the port drives reads back the driven level
// Notes: floating pins take the level the bench forces, changed every test
`timescale 1ns/1ps
`default_nettype none
// ======================================================================
// pin resolution
module dio_pin_model (
   // from the port
   input wire logic [7:0] out,
   input wire logic [7:0] oe_n,
   // level forced from outside
   input wire logic [7:0] ext,
   // back to the port
   output logic [7:0] pin_in
);
   // released bits never echo the last driven value, they follow ext
   assign pin_in = (out & ~oe_n) | (ext & oe_n);
endmodule : dio_pin_model
`default_nettype wire

// File: bench/testbench.sv
// Purpose: self-checking bench for the dual 8-bit i/o ports
// Assumes: apb answers one cycle after setup, pins sync in 2 edges
// Notes: read results are queued by the driver and checked by a monitor
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import dio_pkg::*;
   // ======================================================================
   // signals
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0000_0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'hf;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [7:0] pi [2];
   logic [7:0] po [2];
   logic [7:0] oe [2];
   logic [7:0] ext [2] = '{8'h5a, 8'ha5};
   logic [7:0] lm [2];
   logic [7:0] dm [2];
   logic [33:0] expq [$];
   logic [33:0] e;
   logic [31:0] seed = 32'hc31b_60b6;
   int fail_count = 0;
   int comparisons = 0;
   localparam logic [15:0] DI [2] = '{DIO_IDX_P7_DATA, DIO_IDX_P8_DATA};
   localparam logic [15:0] DR [2] = '{DIO_IDX_P7_DIR, DIO_IDX_P8_DIR};
   localparam dio_mode_t HOLD [3] = '{DIO_MODE_SLEEP, DIO_MODE_SUBSLEEP, DIO_MODE_WATCH};

   dio_ports i_dio_ports (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .prdata, .pready, .pslverr, .port_seven_pin_in(pi[0]),
      .port_seven_pin_out(po[0]), .port_seven_pin_oe_n(oe[0]), .port_eight_pin_in(pi[1]),
      .port_eight_pin_out(po[1]), .port_eight_pin_oe_n(oe[1]));
   dio_pin_model i_m7 (.out(po[0]), .oe_n(oe[0]), .ext(ext[0]), .pin_in(pi[0]));
   dio_pin_model i_m8 (.out(po[1]), .oe_n(oe[1]), .ext(ext[1]), .pin_in(pi[1]));

   always #5 pclk = ~pclk;

   // ======================================================================
   // helpers
   function automatic logic [7:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction : xs

   task automatic cmp(input string n, input logic [31:0] x, input logic [31:0] g);
      comparisons++;
      if (g !== x) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", n, x, g);
      end
   endtask : cmp

   task automatic cmp_pin(input string n, input logic [7:0] x, input logic [7:0] g);
      comparisons++;
      if (g !== x) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", n, x, g);
      end
   endtask : cmp_pin

   task automatic finish_test();
      if (fail_count == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test

   // request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d,
      input logic [33:0] x);
      expq.push_back(x);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {14'h0000, a, 2'b00};
      pwdata <= {24'h00_0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      apb(1'b1, a, d, 34'h0_0000_0000);
   endtask : wr

   task automatic rd(input logic [15:0] a, input logic [7:0] d);
      apb(1'b0, a, 8'h00, {2'b10, 24'h00_0000, d});
   endtask : rd

   // ======================================================================
   // monitor: oldest note against each answer
   always @(posedge pclk) begin
      if (pready === 1'b1) begin
         e = expq.pop_front();
         cmp("pslverr", {31'h0000_0000, e[32]}, {31'h0000_0000, pslverr});
         if (e[33]) cmp("prdata", e[31:0], prdata);
      end
   end

   initial begin
      #100_000;
      fail_count++;
      finish_test();
   end

   // ======================================================================
   // scenarios
   initial begin
      repeat (2) @(posedge pclk);
      cmp_pin("oe7", 8'hff, oe[0]);
      cmp_pin("oe8", 8'hff, oe[1]);
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(DR[0], DIO_WO_READ);
      rd(DR[1], DIO_WO_READ);
      cmp_pin("dir7_rst", 8'hff, oe[0]);
      cmp_pin("dir8_rst", 8'hff, oe[1]);
      apb(1'b0, 16'hffd0, 8'h00, 34'h3_0000_0000);
      for (int p = 0; p < 2; p++) begin
         rd(DI[p], ext[p]);
         wr(DR[p], 8'hff);
         rd(DI[p], 8'h00);
      end
      // a write without lane 0 strobe must leave the latch alone
      pstrb <= 4'h0;
      wr(DI[0], 8'h3c);
      pstrb <= 4'hf;
      rd(DI[0], 8'h00);
      for (int i = 0; i < 6; i++) begin
         for (int p = 0; p < 2; p++) begin
            lm[p] = xs();
            dm[p] = xs();
            ext[p] <= xs();
            wr(DI[p], lm[p]);
            wr(DR[p], dm[p]);
            repeat (3) @(posedge pclk);
            cmp_pin("oe_n", ~dm[p], oe[p]);
            cmp_pin("out", lm[p] & dm[p], po[p] & dm[p]);
            rd(DI[p], (lm[p] & dm[p]) | (ext[p] & ~dm[p]));
         end
      end
      wr(DR[0], 8'hff);
      for (int k = 0; k < 3; k++) begin
         wr(DIO_IDX_MODE, 8'(HOLD[k]));
         wr(DI[0], ~lm[0]);
         repeat (3) @(posedge pclk);
         cmp_pin("held", lm[0], po[0]);
         cmp_pin("held_oe", dm[1] ^ 8'hff, oe[1]);
         lm[0] = ~lm[0];
         wr(DIO_IDX_MODE, 8'(DIO_MODE_SUBACTIVE));
         repeat (3) @(posedge pclk);
         cmp_pin("subactive", lm[0], po[0]);
      end
      wr(DIO_IDX_MODE, 8'(DIO_MODE_STANDBY));
      repeat (3) @(posedge pclk);
      cmp_pin("stby7", 8'hff, oe[0]);
      cmp_pin("stby8", 8'hff, oe[1]);
      wr(DIO_IDX_MODE, 8'(DIO_MODE_ACTIVE));
      repeat (3) @(posedge pclk);
      cmp_pin("active", 8'h00, oe[0]);
      // out of range mode codes are refused, the register keeps its value
      wr(DIO_IDX_MODE, 8'h07);
      rd(DIO_IDX_MODE, 8'(DIO_MODE_ACTIVE));
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      cmp_pin("rst_oe7", 8'hff, oe[0]);
      cmp_pin("rst_oe8", 8'hff, oe[1]);
      presetn <= 1'b1;
      // pins need the two synchroniser edges before a read can see them
      repeat (2) @(posedge pclk);
      rd(DI[0], ext[0]);
      rd(DI[1], ext[1]);
      wr(DR[0], 8'hff);
      rd(DI[0], 8'h00);
      wr(DR[1], 8'hff);
      rd(DI[1], 8'h00);
      repeat (3) @(posedge pclk);
      cmp("queue", 32'h0000_0000, 32'(expq.size()));
      finish_test();
   end
endmodule : testbench
`default_nettype wire
